// ---- pkg/pmc_defs.svh ----
// Contract
// R1 - normal mode clocks core and all peripherals, fully operational
// R2 - core-halt request stops core only; any interrupt wakes the core
// R3 - fast-wake sleep: clocks halted, fast oscillators off, regulators normal bias
// R4 - low-bias sleep: clocks halted, fast oscillators off, regulators low bias
// R5 - in either sleep, timers 3 and 4 may count from slow oscillator
// R6 - sleep ends on timer4, serial, two-wire, port match or comparator rise
// R7 - shutdown-select bit then stop bit removes power from internal nets
// R8 - in shutdown 5 V regulator stays if enabled; pins hold state
// R9 - shutdown ends only by reset pin or power-on reset (code also ends it on SRST_I)
// R10 - after reset system clock is first fast oscillator divided by 8
// R11 - system clock divider divides by 1,2,4,8,16,32,64 or 128
// R12 - each fast oscillator has a selectable divide-by-1.5 pre-scaler
// R13 - each peripheral clock gated off while peripheral unused
// R14 - sleep or halt request bit self-clears when wake ends the mode
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
`define PMC_ADDR_PCA        8'h00
`define PMC_ADDR_PCB        8'h04
`define PMC_ADDR_REG        8'h08
`define PMC_ADDR_CLK        8'h0C
`define PMC_ADDR_PEN        8'h10
`define PMC_ADDR_STAT       8'h14
`define PMC_PCA_HALT        0
`define PMC_PCA_STOP        1
`define PMC_PCB_FAST        0
`define PMC_PCB_LOWB        1
`define PMC_REG_SDSEL       0
`define PMC_REG_V5EN        1
`define PMC_CLK_SEL_LSB     0
`define PMC_CLK_DIV_LSB     4
`define PMC_CLK_PRE_A       8
`define PMC_CLK_PRE_B       9
`define PMC_CLK_RESET       32'h0000_0030
`define PMC_DIV_RESET       3'h3
`define PMC_PEN_RESET       8'hFF
`define PMC_SEL_OSC_A       2'h0
`define PMC_NPER            8
`define PMC_T3              2
`define PMC_T4              3
`define PMC_RESP_OKAY       2'h0
`define PMC_RESP_SLVERR     2'h2
`endif

// ---- pkg/pmc_pkg.sv ----
package pmc_pkg;
  typedef enum logic [2:0] {
    PMC_NORMAL   = 3'h0,
    PMC_HALT     = 3'h1,
    PMC_SLP_FAST = 3'h2,
    PMC_SLP_LOWB = 3'h3,
    PMC_SHUTDOWN = 3'h4
  } pmc_mode_type;
endpackage

// ---- logic/pmc_top.sv ----
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "pmc_defs.svh"
module pmc_top (
  input  wire logic                 CLK_I,
  input  wire logic                 SRST_I,
  input  wire logic                 POR_I,
  input  wire logic                 RESET_PIN_N_I,
  input  wire logic [31:0]          S_AXI_AWADDR_I,
  input  wire logic                 S_AXI_AWVALID_I,
  output logic                      S_AXI_AWREADY_O,
  input  wire logic [31:0]          S_AXI_WDATA_I,
  input  wire logic [3:0]           S_AXI_WSTRB_I,
  input  wire logic                 S_AXI_WVALID_I,
  output logic                      S_AXI_WREADY_O,
  output logic [1:0]                S_AXI_BRESP_O,
  output logic                      S_AXI_BVALID_O,
  input  wire logic                 S_AXI_BREADY_I,
  input  wire logic [31:0]          S_AXI_ARADDR_I,
  input  wire logic                 S_AXI_ARVALID_I,
  output logic                      S_AXI_ARREADY_O,
  output logic [31:0]               S_AXI_RDATA_O,
  output logic [1:0]                S_AXI_RRESP_O,
  output logic                      S_AXI_RVALID_O,
  input  wire logic                 S_AXI_RREADY_I,
  input  wire logic                 IRQ_ANY_I,
  input  wire logic                 WAKE_TIMER4_I,
  input  wire logic                 WAKE_SERIAL_I,
  input  wire logic                 WAKE_TWO_WIRE_I,
  input  wire logic                 WAKE_PORT_MATCH_I,
  input  wire logic                 COMPARATOR0_I,
  output logic                      CORE_CLK_EN_O,
  output logic [`PMC_NPER-1:0]      PERIPH_CLK_EN_O,
  output logic                      T34_SLOW_CLK_EN_O,
  output logic                      FAST_OSC_A_EN_O,
  output logic                      FAST_OSC_B_EN_O,
  output logic                      REG_LOW_BIAS_O,
  output logic                      CORE_POWER_EN_O,
  output logic                      REG_5V_EN_O,
  output logic                      PIN_HOLD_O,
  output logic [1:0]                CLK_SRC_SEL_O,
  output logic [2:0]                CLK_DIV_LOG2_O,
  output logic                      PRESCALE_A_EN_O,
  output logic                      PRESCALE_B_EN_O,
  output pmc_pkg::pmc_mode_type     MODE_O
);
  import pmc_pkg::*;

  typedef struct packed {
    pmc_mode_type          mode;
    logic                  halt_req;
    logic                  fast_req;
    logic                  lowb_req;
    logic                  sd_sel;
    logic                  v5_en;
    logic [1:0]            clk_sel;
    logic [2:0]            clk_div;
    logic                  pre_a;
    logic                  pre_b;
    logic [`PMC_NPER-1:0]  per_en;
    logic                  comp_q;
    logic                  aw_got;
    logic [7:0]            aw_addr;
    logic                  w_got;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  aw_rdy;
    logic                  w_rdy;
    logic                  ar_rdy;
  } pmc_state_type;

  pmc_state_type s_reg;
  pmc_state_type s_next;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `PMC_ADDR_PCA) || (a == `PMC_ADDR_PCB) || (a == `PMC_ADDR_REG) ||
                 (a == `PMC_ADDR_CLK) || (a == `PMC_ADDR_PEN) || (a == `PMC_ADDR_STAT);
  endfunction

  logic sleep_wake;
  logic halt_set;
  logic slp_set;
  logic comp_rise;
  logic do_write;
  logic [31:0] rd_word;
  logic [31:0] wmask;

  assign comp_rise  = COMPARATOR0_I & ~s_reg.comp_q;
  assign sleep_wake = WAKE_TIMER4_I | WAKE_SERIAL_I | WAKE_TWO_WIRE_I |
                      WAKE_PORT_MATCH_I | comp_rise; // R6
  assign do_write   = s_reg.aw_got & s_reg.w_got & ~s_reg.bvalid;
  // a request written in the wake cycle survives the self-clear
  assign halt_set   = do_write & wmask[0] & (s_reg.aw_addr == `PMC_ADDR_PCA) &
                      s_reg.w_data[`PMC_PCA_HALT];
  assign slp_set    = do_write & wmask[0] & (s_reg.aw_addr == `PMC_ADDR_PCB) &
                      (s_reg.clk_sel == `PMC_SEL_OSC_A);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_mask
      assign wmask[g*8 +: 8] = {8{s_reg.w_strb[g]}};
    end
  endgenerate

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (S_AXI_ARADDR_I[7:0])
      `PMC_ADDR_PCA: begin
        rd_word[`PMC_PCA_HALT] = s_reg.halt_req;
      end
      `PMC_ADDR_PCB: begin
        rd_word[`PMC_PCB_FAST] = s_reg.fast_req;
        rd_word[`PMC_PCB_LOWB] = s_reg.lowb_req;
      end
      `PMC_ADDR_REG: begin
        rd_word[`PMC_REG_SDSEL] = s_reg.sd_sel;
        rd_word[`PMC_REG_V5EN]  = s_reg.v5_en;
      end
      `PMC_ADDR_CLK: begin
        rd_word[`PMC_CLK_SEL_LSB +: 2] = s_reg.clk_sel;
        rd_word[`PMC_CLK_DIV_LSB +: 3] = s_reg.clk_div;
        rd_word[`PMC_CLK_PRE_A]        = s_reg.pre_a;
        rd_word[`PMC_CLK_PRE_B]        = s_reg.pre_b;
      end
      `PMC_ADDR_PEN: begin
        rd_word[`PMC_NPER-1:0] = s_reg.per_en;
      end
      `PMC_ADDR_STAT: begin
        rd_word[2:0] = s_reg.mode;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.comp_q = COMPARATOR0_I;
    // axi write channel capture
    if (S_AXI_AWVALID_I && !s_reg.aw_got) begin
      s_next.aw_got  = 1'b1;
      s_next.aw_addr = S_AXI_AWADDR_I[7:0];
    end
    if (S_AXI_WVALID_I && !s_reg.w_got) begin
      s_next.w_got  = 1'b1;
      s_next.w_data = S_AXI_WDATA_I;
      s_next.w_strb = S_AXI_WSTRB_I;
    end
    if (s_reg.bvalid && S_AXI_BREADY_I) begin
      s_next.bvalid = 1'b0;
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
    end
    if (do_write) begin
      s_next.bvalid = 1'b1;
      s_next.bresp  = addr_known(s_reg.aw_addr) ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
      if (wmask[0]) begin
        unique case (s_reg.aw_addr)
          `PMC_ADDR_PCA: begin
            if (s_reg.w_data[`PMC_PCA_HALT])
              s_next.halt_req = 1'b1; // R2
            if (s_reg.w_data[`PMC_PCA_STOP] && s_reg.sd_sel)
              s_next.mode = PMC_SHUTDOWN; // R7
          end
          `PMC_ADDR_PCB: begin
            // entry requires system clock already on first fast oscillator
            if (s_reg.clk_sel == `PMC_SEL_OSC_A) begin
              s_next.fast_req = s_reg.w_data[`PMC_PCB_FAST]; // R3
              s_next.lowb_req = s_reg.w_data[`PMC_PCB_LOWB]; // R4
            end
          end
          `PMC_ADDR_REG: begin
            s_next.sd_sel = s_reg.w_data[`PMC_REG_SDSEL]; // R7
            s_next.v5_en  = s_reg.w_data[`PMC_REG_V5EN];
          end
          `PMC_ADDR_CLK: begin
            s_next.clk_sel = s_reg.w_data[`PMC_CLK_SEL_LSB +: 2];
            s_next.clk_div = s_reg.w_data[`PMC_CLK_DIV_LSB +: 3]; // R11
          end
          `PMC_ADDR_PEN: begin
            s_next.per_en = s_reg.w_data[`PMC_NPER-1:0]; // R13
          end
          default: begin
          end
        endcase
      end
      if (wmask[8] && s_reg.aw_addr == `PMC_ADDR_CLK) begin
        s_next.pre_a = s_reg.w_data[`PMC_CLK_PRE_A]; // R12
        s_next.pre_b = s_reg.w_data[`PMC_CLK_PRE_B]; // R12
      end
    end
    // axi read channel
    if (s_reg.rvalid && S_AXI_RREADY_I) begin
      s_next.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_I && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = rd_word;
      s_next.rresp  = addr_known(S_AXI_ARADDR_I[7:0]) ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
    end
    // mode sequencing
    unique case (s_reg.mode)
      PMC_NORMAL: begin
        if (s_next.mode != PMC_SHUTDOWN) begin
          if (s_reg.lowb_req)
            s_next.mode = PMC_SLP_LOWB; // R4
          else if (s_reg.fast_req)
            s_next.mode = PMC_SLP_FAST; // R3
          else if (s_reg.halt_req)
            s_next.mode = PMC_HALT; // R2
        end
      end
      PMC_HALT: begin
        if (IRQ_ANY_I) begin
          s_next.mode     = PMC_NORMAL; // R2
          if (!halt_set)
            s_next.halt_req = 1'b0; // R14
        end
      end
      PMC_SLP_FAST, PMC_SLP_LOWB: begin
        if (sleep_wake) begin
          s_next.mode     = PMC_NORMAL; // R6
          if (!slp_set) begin
            s_next.fast_req = 1'b0; // R14
            s_next.lowb_req = 1'b0; // R14
          end
        end
      end
      PMC_SHUTDOWN: begin
        s_next.mode = PMC_SHUTDOWN; // R9
      end
      default: begin
        s_next.mode = PMC_NORMAL;
      end
    endcase
    // readies registered so every bus output leaves a flip-flop
    s_next.aw_rdy = ~s_next.aw_got;
    s_next.w_rdy  = ~s_next.w_got;
    s_next.ar_rdy = ~s_next.rvalid;
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I || POR_I || !RESET_PIN_N_I) begin // R9
      s_reg         <= '0;
      s_reg.mode    <= PMC_NORMAL;
      s_reg.clk_sel <= `PMC_SEL_OSC_A; // R10
      s_reg.clk_div <= `PMC_DIV_RESET; // R10
      s_reg.per_en  <= `PMC_PEN_RESET;
      s_reg.aw_rdy  <= 1'b1;
      s_reg.w_rdy   <= 1'b1;
      s_reg.ar_rdy  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I || POR_I || !RESET_PIN_N_I) begin
      CORE_CLK_EN_O     <= 1'b1;
      PERIPH_CLK_EN_O   <= `PMC_PEN_RESET;
      T34_SLOW_CLK_EN_O <= 1'b0;
      FAST_OSC_A_EN_O   <= 1'b1;
      FAST_OSC_B_EN_O   <= 1'b1;
      REG_LOW_BIAS_O    <= 1'b0;
      CORE_POWER_EN_O   <= 1'b1;
      REG_5V_EN_O       <= 1'b0;
      PIN_HOLD_O        <= 1'b0;
      CLK_SRC_SEL_O     <= `PMC_SEL_OSC_A;
      CLK_DIV_LOG2_O    <= `PMC_DIV_RESET;
      PRESCALE_A_EN_O   <= 1'b0;
      PRESCALE_B_EN_O   <= 1'b0;
      MODE_O            <= PMC_NORMAL;
    end else begin
      CORE_CLK_EN_O     <= (s_next.mode == PMC_NORMAL); // R1
      PERIPH_CLK_EN_O   <= (s_next.mode == PMC_NORMAL || s_next.mode == PMC_HALT) ?
                           s_next.per_en : '0; // R13
      T34_SLOW_CLK_EN_O <= (s_next.mode == PMC_SLP_FAST || s_next.mode == PMC_SLP_LOWB) &&
                           (s_next.per_en[`PMC_T3] | s_next.per_en[`PMC_T4]); // R5
      FAST_OSC_A_EN_O   <= (s_next.mode == PMC_NORMAL || s_next.mode == PMC_HALT); // R3
      FAST_OSC_B_EN_O   <= (s_next.mode == PMC_NORMAL || s_next.mode == PMC_HALT); // R4
      REG_LOW_BIAS_O    <= (s_next.mode == PMC_SLP_LOWB); // R4
      CORE_POWER_EN_O   <= (s_next.mode != PMC_SHUTDOWN); // R7
      REG_5V_EN_O       <= s_next.v5_en; // R8
      PIN_HOLD_O        <= (s_next.mode == PMC_SHUTDOWN); // R8
      CLK_SRC_SEL_O     <= s_next.clk_sel;
      CLK_DIV_LOG2_O    <= s_next.clk_div; // R11
      PRESCALE_A_EN_O   <= s_next.pre_a; // R12
      PRESCALE_B_EN_O   <= s_next.pre_b; // R12
      MODE_O            <= s_next.mode;
    end
  end

  assign S_AXI_AWREADY_O = s_reg.aw_rdy;
  assign S_AXI_WREADY_O  = s_reg.w_rdy;
  assign S_AXI_BVALID_O  = s_reg.bvalid;
  assign S_AXI_BRESP_O   = s_reg.bresp;
  assign S_AXI_ARREADY_O = s_reg.ar_rdy;
  assign S_AXI_RVALID_O  = s_reg.rvalid;
  assign S_AXI_RDATA_O   = s_reg.rdata;
  assign S_AXI_RRESP_O   = s_reg.rresp;
endmodule

// ---- tb/pmc_monitor.sv ----
`timescale 1ns/1ns
`include "pmc_defs.svh"
module pmc_monitor (
  input wire logic                  CLK_I,
  input wire logic                  SRST_I,
  input wire logic                  POR_I,
  input wire logic                  RESET_PIN_N_I,
  input wire logic                  IRQ_ANY_I,
  input wire logic                  WAKE_TIMER4_I,
  input wire logic                  WAKE_SERIAL_I,
  input wire logic                  WAKE_TWO_WIRE_I,
  input wire logic                  WAKE_PORT_MATCH_I,
  input wire logic                  COMPARATOR0_I,
  input wire logic                  CORE_CLK_EN_O,
  input wire logic [`PMC_NPER-1:0]  PERIPH_CLK_EN_O,
  input wire logic                  T34_SLOW_CLK_EN_O,
  input wire logic                  FAST_OSC_A_EN_O,
  input wire logic                  FAST_OSC_B_EN_O,
  input wire logic                  REG_LOW_BIAS_O,
  input wire logic                  CORE_POWER_EN_O,
  input wire logic                  REG_5V_EN_O,
  input wire logic                  PIN_HOLD_O,
  input wire pmc_pkg::pmc_mode_type MODE_O
);
  import pmc_pkg::*;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SRST_I || POR_I || !RESET_PIN_N_I);
  sequence s_asleep;
    MODE_O inside {PMC_SLP_FAST, PMC_SLP_LOWB};
  endsequence
  sequence s_wake;
    WAKE_TIMER4_I || WAKE_SERIAL_I || WAKE_TWO_WIRE_I || WAKE_PORT_MATCH_I
      || $rose(COMPARATOR0_I);
  endsequence
  a_normal_run: assert property (
    MODE_O == PMC_NORMAL && $past(MODE_O) == PMC_NORMAL |-> CORE_CLK_EN_O && CORE_POWER_EN_O)
    else $error("normal mode clocks off");
  a_halt_core: assert property (
    MODE_O == PMC_HALT && $stable(MODE_O) |-> !CORE_CLK_EN_O && FAST_OSC_A_EN_O)
    else $error("halt mode clocks wrong");
  a_halt_wake: assert property (MODE_O == PMC_HALT && IRQ_ANY_I |-> ##[1:2] !MODE_O)
    else $error("interrupt left core halted");
  a_sleep_off: assert property (
    s_asleep ##0 $stable(MODE_O) |-> !(CORE_CLK_EN_O || FAST_OSC_A_EN_O || FAST_OSC_B_EN_O))
    else $error("sleep left clocks running");
  a_bias_mode: assert property (
    $stable(MODE_O) |-> REG_LOW_BIAS_O == (MODE_O == PMC_SLP_LOWB))
    else $error("regulator bias wrong");
  a_slow_timer: assert property (T34_SLOW_CLK_EN_O |-> MODE_O inside {PMC_SLP_FAST, PMC_SLP_LOWB})
    else $error("slow timer clock outside sleep");
  a_sleep_wake: assert property (s_asleep ##0 s_wake |-> ##[1:2] MODE_O == PMC_NORMAL)
    else $error("wake event ignored");
  a_shut_power: assert property (
    MODE_O == PMC_SHUTDOWN && $stable(MODE_O) |-> !CORE_POWER_EN_O && PIN_HOLD_O)
    else $error("shutdown power wrong");
  a_shut_stays: assert property (
    MODE_O == PMC_SHUTDOWN && !SRST_I && !POR_I && RESET_PIN_N_I |=> MODE_O == PMC_SHUTDOWN)
    else $error("shutdown left without reset");
  a_v5_kept: assert property (
    MODE_O == PMC_SHUTDOWN && !SRST_I && !POR_I && RESET_PIN_N_I |=> $stable(REG_5V_EN_O))
    else $error("5 V regulator changed");
  a_periph_gate: assert property (
    !(MODE_O inside {PMC_NORMAL, PMC_HALT}) && $stable(MODE_O) |-> PERIPH_CLK_EN_O == 8'h0)
    else $error("peripheral clock left on");
endmodule
bind pmc_top pmc_monitor u_mon (.*);

// ---- tb/pmc_wake_model.sv ----
`timescale 1ns/1ns
module pmc_wake_model (
  input  wire logic       clk_i,
  input  wire logic       fire_i,
  input  wire logic [2:0] sel_i,
  input  wire logic [3:0] hold_i,
  output logic            irq_o,
  output logic [3:0]      wake_o,
  output logic            cmp_o
);
  logic [3:0] cnt_reg = 4'h0;
  logic [2:0] sel_reg = 3'h0;
  logic [5:0] hit;
  always_ff @(posedge clk_i) begin
    if (fire_i) begin
      cnt_reg <= hold_i;
      sel_reg <= sel_i;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
  // source 6 raises every line at once
  assign hit = (cnt_reg == 4'h0) ? 6'h0 : (6'h01 << sel_reg) | {6{sel_reg == 3'h6}};
  assign irq_o = hit[0];
  assign wake_o = hit[4:1];
  assign cmp_o = hit[5];
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
`include "pmc_defs.svh"
module testbench;
  import pmc_pkg::*;
  logic CLK_I = 1'h0, SRST_I = 1'h1, POR_I = 1'h0, RESET_PIN_N_I = 1'h1, fire = 1'h0;
  logic S_AXI_AWVALID_I = 1'h0, S_AXI_WVALID_I = 1'h0, S_AXI_BREADY_I = 1'h0;
  logic S_AXI_ARVALID_I = 1'h0, S_AXI_RREADY_I = 1'h0;
  logic [31:0] S_AXI_AWADDR_I = 32'h0, S_AXI_WDATA_I = 32'h0, S_AXI_ARADDR_I = 32'h0, v;
  logic [3:0] S_AXI_WSTRB_I = 4'hF, hold = 4'h1;
  logic [2:0] sel = 3'h0;
  logic [7:0] pen;
  wire [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, CLK_SRC_SEL_O;
  wire [31:0] S_AXI_RDATA_O;
  wire [7:0] PERIPH_CLK_EN_O;
  wire [2:0] CLK_DIV_LOG2_O;
  wire S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
  wire CORE_CLK_EN_O, T34_SLOW_CLK_EN_O, FAST_OSC_A_EN_O, FAST_OSC_B_EN_O, REG_LOW_BIAS_O;
  wire CORE_POWER_EN_O, REG_5V_EN_O, PIN_HOLD_O, PRESCALE_A_EN_O, PRESCALE_B_EN_O;
  wire IRQ_ANY_I, WAKE_TIMER4_I, WAKE_SERIAL_I, WAKE_TWO_WIRE_I, WAKE_PORT_MATCH_I;
  wire COMPARATOR0_I;
  pmc_mode_type MODE_O;
  int error_cnt = 0, n_compared = 0;
  pmc_top DUT (.*);
  pmc_wake_model u_wake (.clk_i(CLK_I), .fire_i(fire), .sel_i(sel), .hold_i(hold),
    .irq_o(IRQ_ANY_I), .cmp_o(COMPARATOR0_I),
    .wake_o({WAKE_PORT_MATCH_I, WAKE_TWO_WIRE_I, WAKE_SERIAL_I, WAKE_TIMER4_I}));
  initial begin
    forever #25 CLK_I = ~CLK_I;
  end
  task automatic end_sim;
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axi_wr(input logic [31:0] a, d, input logic [1:0] er);
    @(posedge CLK_I);
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= d;
    S_AXI_AWVALID_I <= 1'h1;
    S_AXI_WVALID_I <= 1'h1;
    S_AXI_BREADY_I <= 1'h1;
    do begin
      @(posedge CLK_I);
      if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'h0;
      if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'h0;
    end while (S_AXI_BVALID_O !== 1'h1);
    S_AXI_BREADY_I <= 1'h0;
    chk("bresp", er, S_AXI_BRESP_O);
  endtask
  task automatic axi_rd(input logic [31:0] a, ed, input logic [1:0] er);
    @(posedge CLK_I);
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1'h1;
    S_AXI_RREADY_I <= 1'h1;
    do begin
      @(posedge CLK_I);
      if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'h0;
    end while (S_AXI_RVALID_O !== 1'h1);
    S_AXI_RREADY_I <= 1'h0;
    chk("rdata", ed, S_AXI_RDATA_O);
    chk("rresp", er, S_AXI_RRESP_O);
  endtask
  task automatic wait_mode(input pmc_mode_type m);
    for (int n = 0; n < 20 && MODE_O !== m; n++) @(posedge CLK_I);
    repeat (2) @(posedge CLK_I);
    chk("mode", m, MODE_O);
  endtask
  // pulse one wake source, or every line at once for source 6, for 1 to 7 cycles, then let it die away
  task automatic kick(input logic [2:0] s);
    sel <= s;
    hold <= 4'h1 + 4'($urandom_range(0, 6));
    fire <= 1'h1;
    @(posedge CLK_I);
    fire <= 1'h0;
    repeat (8) @(posedge CLK_I);
  endtask
  initial begin
    repeat (20000) @(posedge CLK_I);
    error_cnt++;
    end_sim;
  end
  initial begin
    void'($urandom(32'hC8C9));
    repeat (5) @(posedge CLK_I);
    SRST_I <= 1'h0;
    @(posedge CLK_I);
    chk("reset", {1'h1, `PMC_PEN_RESET, `PMC_SEL_OSC_A, `PMC_DIV_RESET},
        {CORE_CLK_EN_O, PERIPH_CLK_EN_O, CLK_SRC_SEL_O, CLK_DIV_LOG2_O});
    axi_rd(`PMC_ADDR_CLK, `PMC_CLK_RESET, `PMC_RESP_OKAY);
    axi_rd(`PMC_ADDR_PEN, 32'hFF, `PMC_RESP_OKAY);
    for (int d = 0; d < 8; d++) begin
      v = {22'h0, 2'($urandom_range(0, 3)), 1'h0, 3'(d), 4'h0};
      axi_wr(`PMC_ADDR_CLK, v, `PMC_RESP_OKAY);
      @(posedge CLK_I);
      chk("clk", v[9:4], {PRESCALE_B_EN_O, PRESCALE_A_EN_O, 1'h0, CLK_DIV_LOG2_O});
      axi_rd(`PMC_ADDR_CLK, v, `PMC_RESP_OKAY);
    end
    S_AXI_WSTRB_I <= 4'h1;
    axi_wr(`PMC_ADDR_CLK, v ^ 32'h320, `PMC_RESP_OKAY);
    S_AXI_WSTRB_I <= 4'hF;
    axi_rd(`PMC_ADDR_CLK, v ^ 32'h20, `PMC_RESP_OKAY);
    axi_wr(32'h18, 32'hFFFF_FFFF, `PMC_RESP_SLVERR);
    axi_rd(32'h1C, 32'h0, `PMC_RESP_SLVERR);
    for (int s = 1; s < 6; s++) begin
      pen = 8'($urandom);
      axi_wr(`PMC_ADDR_PEN, 32'(pen), `PMC_RESP_OKAY);
      axi_wr(`PMC_ADDR_PCB, s[0] ? 32'h1 : 32'h2, `PMC_RESP_OKAY);
      wait_mode(s[0] ? PMC_SLP_FAST : PMC_SLP_LOWB);
      chk("bias", !s[0], REG_LOW_BIAS_O);
      chk("osc", 32'h0, {FAST_OSC_A_EN_O, FAST_OSC_B_EN_O, CORE_CLK_EN_O, PERIPH_CLK_EN_O});
      chk("t34", |pen[3:2], T34_SLOW_CLK_EN_O);
      kick(3'(s));
      wait_mode(PMC_NORMAL);
      chk("periph", pen, PERIPH_CLK_EN_O);
      axi_rd(`PMC_ADDR_PCB, 32'h0, `PMC_RESP_OKAY);
    end
    axi_wr(`PMC_ADDR_PCA, 32'h1, `PMC_RESP_OKAY);
    wait_mode(PMC_HALT);
    chk("halt", 32'h1, {CORE_CLK_EN_O, FAST_OSC_A_EN_O});
    kick(3'h0);
    wait_mode(PMC_NORMAL);
    axi_rd(`PMC_ADDR_PCA, 32'h0, `PMC_RESP_OKAY);
    axi_wr(`PMC_ADDR_CLK, 32'h71, `PMC_RESP_OKAY);
    axi_wr(`PMC_ADDR_PCB, 32'h1, `PMC_RESP_OKAY);
    axi_wr(`PMC_ADDR_PCA, 32'h2, `PMC_RESP_OKAY);
    wait_mode(PMC_NORMAL);
    chk("src", 32'h1, CLK_SRC_SEL_O);
    axi_wr(`PMC_ADDR_REG, 32'h3, `PMC_RESP_OKAY);
    axi_wr(`PMC_ADDR_PCA, 32'h2, `PMC_RESP_OKAY);
    wait_mode(PMC_SHUTDOWN);
    chk("power", 32'h3, {CORE_POWER_EN_O, REG_5V_EN_O, PIN_HOLD_O});
    kick(3'h6);
    chk("mode", PMC_SHUTDOWN, MODE_O);
    RESET_PIN_N_I <= 1'h0;
    @(posedge CLK_I);
    RESET_PIN_N_I <= 1'h1;
    wait_mode(PMC_NORMAL);
    chk("div", 32'h103, {CORE_POWER_EN_O, 5'h0, CLK_DIV_LOG2_O});
    axi_wr(`PMC_ADDR_PEN, 32'h0, `PMC_RESP_OKAY);
    POR_I <= 1'h1;
    repeat (2) @(posedge CLK_I);
    POR_I <= 1'h0;
    @(posedge CLK_I);
    chk("periph", 32'hFF, PERIPH_CLK_EN_O);
    end_sim;
  end
endmodule
